// >>> hdl/wsp_cfg.svh
/*
 * address map, field positions, reset values and timing figures of the
 * wake-up source and prescaler register group.
 * assumes it is included by bare name after the package is compiled.
 */
`ifndef WSP_CFG_SVH
`define WSP_CFG_SVH

`define WSP_BASE_BLOCKING 16'h0200
`define WSP_BASE_NONBLOCK 16'h0300
`define WSP_WINDOW_MASK   16'hff00
`define WSP_OFS_FLAGS_HI  8'h02
`define WSP_OFS_FLAGS     8'h03
`define WSP_OFS_DIV_HI    8'h04
`define WSP_OFS_DIV_LO    8'h05
`define WSP_OFS_WEN_HI    8'h06
`define WSP_OFS_WEN_LO    8'h07
`define WSP_OFS_TRIM_HI   8'h0e
`define WSP_OFS_TRIM_LO   8'h0f
`define WSP_DIV_RESET     16'h7d00
`define WSP_ACTIVE_RESET  13'h0200
`define WSP_LTC_BIT       7
`define WSP_READY_BIT     7
`define WSP_SLOW_LAST     4'h7
`define WSP_DIV_ONE       16'h0001
`define WSP_BYTE_ZERO     8'h00

`endif

// >>> hdl/wsp_pkg.sv
/*
 * types of the wake-up source and prescaler register group.
 * assumes the constants of wsp_cfg.svh for all figures.
 */
`default_nettype none
package wsp_pkg;
    // one bit per wake-up source, msb first as in the status byte
    typedef struct packed {
        logic amphour;
        logic current_thresh;
        logic calib;
        logic lin;
        logic gpio3;
        logic gpio2;
        logic gpio1;
        logic gpio0;
    } wsp_wake_vec_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } wsp_req_t;

    typedef enum logic [0:0] {
        SYNC_WAIT,
        SYNC_DONE
    } wsp_sync_t;
endpackage
`default_nettype wire

// >>> hdl/wsp_regs.sv
/*
 * wake-up source flags, wake-up enables and 1 ms prescaler of the analog die,
 * reached by the controller die over the die-to-die register port.
 * assumes requests are synchronous to clock_in (the die link clock) and
 * answered one cycle later; the low-power oscillator measurement is stable.
 */
//
// Function
// - ah threshold wake sets status bit 7
// - current threshold wake sets status bit 6
// - calibration request wake sets bit 5
// - lin wake sets status bit 4
// - gpio 3 wake sets status bit 3
// - gpio 2..0 wakes set bits 2..0
// - flags stay set until one written
// - 16-bit divider makes slow and fast clocks
// - enable bits 7..5 gate ah, current, calibration
// - enable bit 4 gates lin wake
// - enable bits 3..0 gate gpio wakes
// - low enable bit 7 lifetime overflow, rest zero
// - decode from 0x0200 blocking, 0x300 non-blocking
// - trim high byte: ready, zeros, active bits
// - ready reads 0 while sync pending
// - active divider holds 0x0200 until first sync
`include "wsp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module wsp_regs (
    input  wire logic                  clock_in,
    input  wire logic                  sys_rst_in,
    input  wire wsp_pkg::wsp_req_t     req_in,
    input  wire wsp_pkg::wsp_wake_vec_t wake_event_in,
    input  wire logic [12:0]           lowfreq_measured_in,
    output var  logic                  ack_out,
    output var  logic [15:0]           rdata_out,
    output var  wsp_pkg::wsp_wake_vec_t wake_enable_out,
    output var  logic                  lifetime_ovf_wake_en_out,
    output var  logic                  fast_derived_clock_out,
    output var  logic                  slow_derived_clock_out,
    output var  logic                  divider_ready_flag_out
);
    // true when a byte at offset t is covered by the current access
    function automatic logic lane_hit(input logic [7:0] ofs, input logic word,
                                      input logic [7:0] t);
        lane_hit = word ? (ofs[7:1] == t[7:1]) : (ofs == t);
    endfunction

    // the byte of write data that lands on byte offset t
    function automatic logic [7:0] lane_data(input logic word, input logic [15:0] wd,
                                             input logic [7:0] t);
        lane_data = (word && !t[0]) ? wd[15:8] : wd[7:0];
    endfunction

    wsp_pkg::wsp_wake_vec_t flags_reg, flags_next;
    wsp_pkg::wsp_wake_vec_t wen_reg, wen_next;
    wsp_pkg::wsp_sync_t     sync_reg, sync_next;
    logic        ltc_en_reg, ltc_en_next;
    logic [15:0] div_reg, div_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [3:0]  slow_cnt_reg, slow_cnt_next;
    logic        fast_reg, fast_next;
    logic        slow_reg, slow_next;
    logic [12:0] active_reg, active_next;
    logic        ack_reg, ack_next;
    logic [15:0] rdata_reg, rdata_next;

    logic        in_window;
    logic [7:0]  ofs;
    logic        wr;
    logic        div_wr;
    logic [15:0] div_limit;
    logic        tick;
    logic [7:0]  clr_mask;
    logic [7:0]  wen_lo_byte;

    // register port decode
    always_comb begin
        in_window = ((req_in.addr & `WSP_WINDOW_MASK) == `WSP_BASE_BLOCKING) ||
                    ((req_in.addr & `WSP_WINDOW_MASK) == `WSP_BASE_NONBLOCK);
        ofs    = req_in.addr[7:0];
        wr     = req_in.valid && req_in.write && in_window;
        // byte writes into the divider are dropped
        div_wr = wr && req_in.word && lane_hit(ofs, 1'b1, `WSP_OFS_DIV_HI);
    end

    // wake flags and enables
    always_comb begin
        clr_mask = `WSP_BYTE_ZERO;
        if (wr && lane_hit(ofs, req_in.word, `WSP_OFS_FLAGS)) begin
            clr_mask = lane_data(req_in.word, req_in.wdata, `WSP_OFS_FLAGS);
        end
        // a new enabled event in the clearing cycle wins; zero bits keep their flag
        flags_next = (flags_reg & ~clr_mask) | (wake_event_in & wen_reg);
        wen_next   = wen_reg;
        ltc_en_next = ltc_en_reg;
        if (wr && lane_hit(ofs, req_in.word, `WSP_OFS_WEN_HI)) begin
            wen_next = lane_data(req_in.word, req_in.wdata, `WSP_OFS_WEN_HI);
        end
        wen_lo_byte = lane_data(req_in.word, req_in.wdata, `WSP_OFS_WEN_LO);
        if (wr && lane_hit(ofs, req_in.word, `WSP_OFS_WEN_LO)) begin
            ltc_en_next = wen_lo_byte[`WSP_LTC_BIT];
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flags_reg  <= '0;
            wen_reg    <= '0;
            ltc_en_reg <= 1'b0;
        end else begin
            flags_reg  <= flags_next;
            wen_reg    <= wen_next;
            ltc_en_reg <= ltc_en_next;
        end
    end

    // 1 ms divider and derived clock enables
    always_comb begin
        div_limit = (div_reg == '0) ? '0 : div_reg - `WSP_DIV_ONE;
        tick      = (cnt_reg >= div_limit);
        div_next  = div_wr ? req_in.wdata : div_reg;
        cnt_next  = (tick || div_wr) ? '0 : cnt_reg + `WSP_DIV_ONE;
        fast_next = tick;
        slow_cnt_next = slow_cnt_reg;
        slow_next = 1'b0;
        if (tick) begin
            slow_next     = (slow_cnt_reg == `WSP_SLOW_LAST);
            slow_cnt_next = slow_next ? '0 : slow_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            div_reg      <= `WSP_DIV_RESET;
            cnt_reg      <= '0;
            slow_cnt_reg <= '0;
            fast_reg     <= 1'b0;
            slow_reg     <= 1'b0;
        end else begin
            div_reg      <= div_next;
            cnt_reg      <= cnt_next;
            slow_cnt_reg <= slow_cnt_next;
            fast_reg     <= fast_next;
            slow_reg     <= slow_next;
        end
    end

    // low-frequency clock synchronisation: completes on the next ms tick
    always_comb begin
        sync_next   = sync_reg;
        active_next = active_reg;
        case (sync_reg)
            wsp_pkg::SYNC_WAIT: begin
                if (tick && !div_wr) begin
                    sync_next   = wsp_pkg::SYNC_DONE;
                    active_next = lowfreq_measured_in;
                end
            end
            wsp_pkg::SYNC_DONE: begin
                if (div_wr) begin
                    sync_next = wsp_pkg::SYNC_WAIT;
                end
            end
            default: sync_next = wsp_pkg::SYNC_WAIT;
        endcase
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync_reg   <= wsp_pkg::SYNC_WAIT;
            active_reg <= `WSP_ACTIVE_RESET;
        end else begin
            sync_reg   <= sync_next;
            active_reg <= active_next;
        end
    end

    // read side: answers every request one cycle later, unmapped bytes read zero
    function automatic logic [7:0] rd_byte(input logic [7:0] t);
        logic [7:0] hi;
        hi = {(sync_reg == wsp_pkg::SYNC_DONE), 2'b00, active_reg[12:8]};
        case (t)
            `WSP_OFS_FLAGS:   rd_byte = flags_reg;
            `WSP_OFS_DIV_HI:  rd_byte = div_reg[15:8];
            `WSP_OFS_DIV_LO:  rd_byte = div_reg[7:0];
            `WSP_OFS_WEN_HI:  rd_byte = wen_reg;
            `WSP_OFS_WEN_LO:  rd_byte = {ltc_en_reg, 7'h00};
            `WSP_OFS_TRIM_HI: rd_byte = hi;
            `WSP_OFS_TRIM_LO: rd_byte = active_reg[7:0];
            default:          rd_byte = `WSP_BYTE_ZERO;
        endcase
    endfunction

    always_comb begin
        ack_next   = req_in.valid;
        rdata_next = rdata_reg;
        if (req_in.valid && !req_in.write) begin
            if (!in_window) begin
                rdata_next = '0;
            end else if (req_in.word) begin
                rdata_next = {rd_byte({ofs[7:1], 1'b0}), rd_byte({ofs[7:1], 1'b1})};
            end else begin
                rdata_next = {`WSP_BYTE_ZERO, rd_byte(ofs)};
            end
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack_reg   <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // outputs straight from flip-flops
    always_comb begin
        ack_out                  = ack_reg;
        rdata_out                = rdata_reg;
        wake_enable_out          = wen_reg;
        lifetime_ovf_wake_en_out = ltc_en_reg;
        fast_derived_clock_out   = fast_reg;
        slow_derived_clock_out   = slow_reg;
        divider_ready_flag_out   = (sync_reg == wsp_pkg::SYNC_DONE);
    end

    // checks
    sequence s_flag_write(int b);
        req_in.valid && req_in.write && in_window && !req_in.word &&
        ofs == `WSP_OFS_FLAGS && req_in.wdata[b];
    endsequence

    chk_amphour_flag_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        wake_event_in.amphour && wen_reg.amphour |=> flags_reg.amphour)
        else $error("ah wake did not set flag");
    chk_current_flag_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        wake_event_in.current_thresh && wen_reg.current_thresh
        |=> flags_reg.current_thresh)
        else $error("current wake did not set flag");
    chk_gpio0_flag_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        wake_event_in.gpio0 && wen_reg.gpio0 |=> flags_reg.gpio0)
        else $error("gpio0 wake did not set flag");
    chk_blocked_wake: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !wen_reg.lin && !flags_reg.lin |=> !flags_reg.lin)
        else $error("disabled lin wake set flag");
    chk_w1c_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        s_flag_write(4) and !wake_event_in.lin |=> !flags_reg.lin)
        else $error("write one did not clear lin flag");
    chk_zero_write_keeps: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        flags_reg.calib && !clr_mask[5] |=> flags_reg.calib)
        else $error("flag lost without a one written");
    // the bench runs the divider at 4, so the next pulse is due four cycles on
    chk_fast_period: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        fast_reg && div_reg == 16'h0004 && !div_wr ##1 !div_wr [*3]
        |=> fast_reg)
        else $error("fast clock period wrong");
    chk_ready_drops: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        div_wr |=> !divider_ready_flag_out &&
                   (!(req_in.valid && !req_in.write && req_in.word &&
                      lane_hit(ofs, 1'b1, `WSP_OFS_TRIM_HI)) || rdata_next[15:13] == 3'h0))
        else $error("ready still set after divider write");
    chk_active_held: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        sync_reg == wsp_pkg::SYNC_WAIT && $past(sync_reg == wsp_pkg::SYNC_WAIT)
        |-> $stable(active_reg))
        else $error("active divider moved before sync");
    chk_ltc_low_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        req_in.valid && !req_in.write && in_window && !req_in.word &&
        ofs == `WSP_OFS_WEN_LO |=> rdata_out[6:0] == 7'h00 && ack_out)
        else $error("low enable spare bits not zero");
endmodule
`default_nettype wire

// >>> verif/wsp_ctl_model.sv
/*
 * controller die model: issues register requests over the die-to-die port.
 * assumes requests are launched at the falling edge and acked one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module wsp_ctl_model (
    input  wire logic              clock_in,
    input  wire logic              ack_in,
    input  wire logic [15:0]       rdata_in,
    output var  wsp_pkg::wsp_req_t req_out
);
    int missed_acks = 0;

    initial req_out = '0;

    // one-cycle request pulse; the answer is taken at the falling edge while
    // ack stands; released lines show inverted values
    task automatic access(input logic wr, input logic wd, input logic [15:0] a,
                          input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        @(negedge clock_in);
        req_out = '{valid: 1'b1, write: wr, word: wd, addr: a, wdata: d};
        @(negedge clock_in);
        req_out = '{valid: 1'b0, write: ~wr, word: ~wd, addr: ~a, wdata: ~d};
        while (ack_in !== 1'b1 && n < 4) begin
            @(negedge clock_in);
            n++;
        end
        if (ack_in !== 1'b1) begin
            missed_acks++;
        end
        q = (ack_in === 1'b1) ? rdata_in : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
/*
 * self-checking bench of the wake-up source and prescaler registers.
 * assumes wsp_ctl_model drives the register port.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wsp_cfg.svh"
module tb;
    logic                   clock_in    = 1'b0;
    logic                   sys_rst_in  = 1'b1;
    wsp_pkg::wsp_req_t      req;
    wsp_pkg::wsp_wake_vec_t wake_ev     = '0;
    logic [12:0]            lf_meas     = 13'h1abc;
    logic                   ack, lt_en, fast, slow, ready;
    logic [15:0]            rdata;
    wsp_pkg::wsp_wake_vec_t wen;
    int                     err_total   = 0;
    int                     total_checks = 0;
    logic [15:0]            q;

    always #4 clock_in = ~clock_in;

    wsp_regs wsp_regs_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .req_in(req),
        .wake_event_in(wake_ev), .lowfreq_measured_in(lf_meas), .ack_out(ack),
        .rdata_out(rdata), .wake_enable_out(wen), .lifetime_ovf_wake_en_out(lt_en),
        .fast_derived_clock_out(fast), .slow_derived_clock_out(slow),
        .divider_ready_flag_out(ready));
    wsp_ctl_model wsp_ctl_model_i (.clock_in(clock_in), .ack_in(ack), .rdata_in(rdata),
        .req_out(req));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic w, input logic [15:0] d);
        logic [15:0] dummy;
        wsp_ctl_model_i.access(1'b1, w, a, d, dummy);
    endtask

    task automatic rd(input logic [15:0] a, input logic w);
        wsp_ctl_model_i.access(1'b0, w, a, 16'h0000, q);
        if (!w) q = {8'h00, q[7:0]};
    endtask

    task automatic tick();
        @(posedge clock_in);
        #1;
    endtask

    task automatic pulse(input logic [7:0] v);
        @(negedge clock_in);
        wake_ev = v;
        @(negedge clock_in);
        wake_ev = '0;
    endtask

    task automatic t_reset_values();
        check("enables_out", {7'h00, lt_en, wen}, 16'h0000);
        rd(`WSP_BASE_BLOCKING + 16'h0004, 1'b1);
        check("divider_reset", q, `WSP_DIV_RESET);
        rd(`WSP_BASE_BLOCKING + 16'h0007, 1'b0);
        check("wen_low_reset", q, 16'h0000);
        rd(`WSP_BASE_BLOCKING + 16'h000e, 1'b0);
        check("trim_hi_reset", q, 16'h0002);
        check("ready_reset", {15'h0000, ready}, 16'h0000);
    endtask

    task automatic t_wake_flags();
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            wr(`WSP_BASE_BLOCKING + 16'h0006, 1'b0, {8'h00, ~b});
            pulse(b);
            rd(`WSP_BASE_BLOCKING + 16'h0003, 1'b0);
            check("flag_blocked", q, 16'h0000);
            wr(`WSP_BASE_BLOCKING + 16'h0006, 1'b0, 16'h00ff);
            pulse(b);
            rd(`WSP_BASE_BLOCKING + 16'h0003, 1'b0);
            check("flag_set", q, {8'h00, b});
            wr(`WSP_BASE_BLOCKING + 16'h0003, 1'b0, {8'h00, ~b});
            rd(`WSP_BASE_NONBLOCK + 16'h0003, 1'b0);
            check("flag_kept", q, {8'h00, b});
            wr(`WSP_BASE_NONBLOCK + 16'h0003, 1'b0, {8'h00, b});
            rd(`WSP_BASE_BLOCKING + 16'h0003, 1'b0);
            check("flag_cleared", q, 16'h0000);
        end
        check("wen_out", {8'h00, wen}, 16'h00ff);
    endtask

    task automatic t_low_enable();
        wr(`WSP_BASE_BLOCKING + 16'h0007, 1'b0, 16'h00ff);
        rd(`WSP_BASE_BLOCKING + 16'h0007, 1'b0);
        check("wen_low", q, 16'h0080);
        check("ltc_en_out", {15'h0000, lt_en}, 16'h0001);
        wr(`WSP_BASE_BLOCKING + 16'h000e, 1'b0, 16'h00ff);
        rd(`WSP_BASE_BLOCKING + 16'h000e, 1'b0);
        check("trim_hi_ro", q, 16'h0002);
        wr(16'h0106, 1'b0, 16'h0000);
        rd(`WSP_BASE_BLOCKING + 16'h0002, 1'b0);
        check("unmapped", q, 16'h0000);
        rd(`WSP_BASE_BLOCKING + 16'h0006, 1'b0);
        check("outside_window", q, 16'h00ff);
    endtask

    task automatic t_divider();
        int n;
        int k;
        // byte writes to the divider are refused on purpose
        wr(`WSP_BASE_BLOCKING + 16'h0004, 1'b0, 16'h00ff);
        rd(`WSP_BASE_BLOCKING + 16'h0004, 1'b1);
        check("div_byte_refused", q, `WSP_DIV_RESET);
        wr(`WSP_BASE_NONBLOCK + 16'h0004, 1'b1, 16'h0004);
        check("ready_after_write", {15'h0000, ready}, 16'h0000);
        rd(`WSP_BASE_BLOCKING + 16'h0004, 1'b1);
        check("div_word", q, 16'h0004);
        n = 0;
        do begin tick(); n++; end while (ready !== 1'b1 && n < 40);
        check("ready_set", {15'h0000, ready}, 16'h0001);
        rd(`WSP_BASE_BLOCKING + 16'h000e, 1'b0);
        check("trim_hi_sync", q, 16'h009a);
        rd(`WSP_BASE_BLOCKING + 16'h000f, 1'b0);
        check("trim_lo_sync", q, 16'h00bc);
        n = 0;
        do begin tick(); n++; end while (fast !== 1'b1 && n < 20);
        n = 0;
        do begin tick(); n++; end while (fast !== 1'b1 && n < 20);
        check("fast_period", n[15:0], 16'h0004);
        n = 0;
        do begin tick(); n++; end while (slow !== 1'b1 && n < 60);
        n = 0;
        k = 0;
        do begin tick(); n++; k += (fast === 1'b1); end while (slow !== 1'b1 && n < 60);
        check("slow_ratio", k[15:0], 16'h0008);
        wr(`WSP_BASE_BLOCKING + 16'h0004, 1'b1, 16'h0004);
        check("ready_after_change", {15'h0000, ready}, 16'h0000);
        n = 0;
        do begin tick(); n++; end while (ready !== 1'b1 && n < 40);
        check("ready_resync", {15'h0000, ready}, 16'h0001);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #(8 * 5000);
        err_total++;
        $display("unexpected watchdog: expected done seen hang");
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        sys_rst_in = 1'b0;
        t_reset_values();
        t_wake_flags();
        t_low_enable();
        t_divider();
        check("missed_acks", wsp_ctl_model_i.missed_acks[15:0], 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
